// ===== hdl/exec_pkg.sv
// package for the table write, test-and-skip and exclusive-OR execute block
// assumes a core clock split into four phases per instruction cycle
// Function
// - The table write opcode is 0000 0000 0000 11nn and nn picks keep, post-inc, post-dec or pre-inc of the pointer.
// - A table write puts the table latch byte into the holding register picked by the pointer's three low bits.
// - The table pointer is a 21-bit byte address and increments and decrements act on all of it.
// - Pointer bit 0 picks the low byte of a program word when 0 and the high byte when 1.
// - A table write is one word and two instruction cycles, touches no flag and only loads a holding register.
// - Test-and-skip is 0110 011a plus an address and drops the fetched next instruction when the register is zero.
// - Test-and-skip takes one cycle, two when it skips, three when it skips a two-word instruction, and touches no flag.
// - An access bit of 0 picks the fixed access bank and 1 picks the bank in the bank select value.
// - Literal exclusive-OR 0000 1010 kkkk kkkk puts the working register XOR k in the working register in one cycle.
// - File exclusive-OR 0001 10da XORs the working and file registers in one cycle into W when d is 0, else into f.
`default_nettype none
package exec_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int INSTR_W    = 16;
  localparam int BYTE_W     = 8;
  localparam int TP_W       = 21;
  localparam int BANK_W     = 4;
  localparam int FADDR_W    = 12;
  localparam int HOLD_N     = 8;
  localparam int HOLD_IDX_W = 3;
  localparam int REG_ADDR_W = 4;
  localparam int PHASE_W    = 2;

  ////////////////////////////////////////////////////////////////////////////
  // instruction phases
  localparam logic [PHASE_W-1:0] PH_Q1 = 2'h0;
  localparam logic [PHASE_W-1:0] PH_Q2 = 2'h1;
  localparam logic [PHASE_W-1:0] PH_Q3 = 2'h2;
  localparam logic [PHASE_W-1:0] PH_Q4 = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // opcode patterns and field positions
  localparam logic [13:0] OP_TW_PREFIX  = 14'h0003;
  localparam logic [6:0]  OP_TST_PREFIX = 7'h33;
  localparam logic [7:0]  OP_XL_PREFIX  = 8'h0A;
  localparam logic [5:0]  OP_XF_PREFIX  = 6'h06;
  localparam int          FLD_A_BIT     = 8;
  localparam int          FLD_D_BIT     = 9;

  // pointer modes of the table write
  localparam logic [1:0] TP_KEEP    = 2'h0;
  localparam logic [1:0] TP_POSTINC = 2'h1;
  localparam logic [1:0] TP_POSTDEC = 2'h2;
  localparam logic [1:0] TP_PREINC  = 2'h3;

  // fixed access bank
  localparam logic [BANK_W-1:0] ACCESS_BANK = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // register map of the plain register port
  localparam logic [REG_ADDR_W-1:0] REG_W        = 4'h0;
  localparam logic [REG_ADDR_W-1:0] REG_STATUS   = 4'h1;
  localparam logic [REG_ADDR_W-1:0] REG_TP_LOW   = 4'h2;
  localparam logic [REG_ADDR_W-1:0] REG_TP_HIGH  = 4'h3;
  localparam logic [REG_ADDR_W-1:0] REG_TP_UPPER = 4'h4;
  localparam logic [REG_ADDR_W-1:0] REG_LATCH    = 4'h5;
  localparam logic [REG_ADDR_W-1:0] REG_BANK     = 4'h6;
  localparam int                    HOLD_SEL_BIT = 3;
  localparam int                    STAT_Z_BIT   = 2;
  localparam int                    STAT_N_BIT   = 4;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [BYTE_W-1:0] W_RESET     = 8'h00;
  localparam logic [TP_W-1:0]   TP_RESET    = 21'h000000;
  localparam logic [BYTE_W-1:0] LATCH_RESET = 8'h00;
  localparam logic [BANK_W-1:0] BANK_RESET  = 4'h0;
  localparam logic [BYTE_W-1:0] HOLD_RESET  = 8'hFF;

  // execution states
  typedef enum logic [1:0] {ST_EXEC, ST_TW2, ST_SKIP, ST_SKIP2} state_t;

endpackage
`default_nettype wire

// ===== hdl/hold_if.sv
// interface between the execute logic and the holding register bank
// assumes both ends run on the same core clock
`timescale 1ns/100ps
`default_nettype none
interface hold_if;
  import exec_pkg::*;
  logic                  wr_en;
  logic [HOLD_IDX_W-1:0] wr_idx;
  logic [BYTE_W-1:0]     wr_data;
  logic [HOLD_IDX_W-1:0] rd_idx;
  logic [BYTE_W-1:0]     rd_data;

  modport core (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
  modport bank (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface
`default_nettype wire

// ===== hdl/holding_bank.sv
// eight holding registers filled by table writes
// assumes writes arrive from the execute logic on the core clock
`timescale 1ns/100ps
`default_nettype none
module holding_bank (
  // clock and reset
  input  wire logic mclk,
  input  wire logic reset_n,
  // execute side
  hold_if.bank      hb
);
  import exec_pkg::*;

  logic [BYTE_W-1:0] store      [HOLD_N];
  logic [BYTE_W-1:0] next_store [HOLD_N];

  ////////////////////////////////////////////////////////////////////////////
  // one entry per holding register
  genvar g;
  generate
    for (g = 0; g < HOLD_N; g++) begin : g_entry
      // load when the write index names this entry
      always_comb begin
        next_store[g] = store[g];
        if (hb.wr_en && hb.wr_idx == HOLD_IDX_W'(g)) begin
          next_store[g] = hb.wr_data;
        end
      end

      always_ff @(posedge mclk) begin
        if (!reset_n) begin
          store[g] <= HOLD_RESET;
        end else begin
          store[g] <= next_store[g];
        end
      end
    end
  endgenerate

  // read port for the register bus
  assign hb.rd_data = store[hb.rd_idx];

  a_hold_write_lands: assert property (@(posedge mclk) disable iff (!reset_n)
    hb.wr_en |=> store[$past(hb.wr_idx)] == $past(hb.wr_data))
    else $error("holding register did not take the written byte");

endmodule // holding_bank
`default_nettype wire

// ===== hdl/table_write_test_xor_exec.sv
// execute logic for table write, test-and-skip and the two exclusive-OR ops
// assumes a fetch unit presenting the next word and a data memory that
// answers a read strobe with data in the following clock
`timescale 1ns/100ps
`default_nettype none
module table_write_test_xor_exec (
  // clock and reset
  input  wire logic                               mclk,
  input  wire logic                               reset_n,
  // instruction fetch
  input  wire logic [exec_pkg::INSTR_W-1:0]       instr_word,
  input  wire logic                               instr_two_word,
  output logic                                    instr_load,
  output logic                                    instr_discard,
  // file register memory
  output logic [exec_pkg::FADDR_W-1:0]            file_addr,
  output logic                                    file_rd,
  input  wire logic [exec_pkg::BYTE_W-1:0]        file_rdata,
  output logic                                    file_wr,
  output logic [exec_pkg::BYTE_W-1:0]             file_wdata,
  // program memory pointer
  output logic [exec_pkg::TP_W-1:0]               table_pointer,
  // register port
  input  wire logic [exec_pkg::REG_ADDR_W-1:0]    reg_addr,
  input  wire logic [exec_pkg::BYTE_W-1:0]        reg_wdata,
  input  wire logic                               reg_wr,
  input  wire logic                               reg_rd,
  output logic [exec_pkg::BYTE_W-1:0]             reg_rdata
);
  import exec_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [PHASE_W-1:0] phase;
  logic [PHASE_W-1:0] next_phase;
  state_t             state;
  state_t             next_state;
  logic [INSTR_W-1:0] instr;
  logic [INSTR_W-1:0] next_instr;
  logic [BYTE_W-1:0]  w_reg;
  logic [BYTE_W-1:0]  next_w_reg;
  logic               flag_n;
  logic               next_flag_n;
  logic               flag_z;
  logic               next_flag_z;
  logic [TP_W-1:0]    next_table_pointer;
  logic [BYTE_W-1:0]  table_latch;
  logic [BYTE_W-1:0]  next_table_latch;
  logic [BANK_W-1:0]  bank_select_value;
  logic [BANK_W-1:0]  next_bank_select_value;
  logic [FADDR_W-1:0] next_file_addr;
  logic               next_file_rd;
  logic               next_file_wr;
  logic [BYTE_W-1:0]  next_file_wdata;
  logic               two_word_seen;
  logic               next_two_word_seen;
  logic [BYTE_W-1:0]  hold_data;
  logic [BYTE_W-1:0]  next_hold_data;
  logic [BYTE_W-1:0]  next_reg_rdata;
  logic               is_tw;
  logic               is_tst;
  logic               is_xl;
  logic               is_xf;
  logic               cur_a;
  logic               cur_d;
  logic [1:0]         cur_nn;
  logic [BYTE_W-1:0]  cur_f;
  logic [BYTE_W-1:0]  xor_res;

  hold_if hb ();

  holding_bank u_holding_bank (
    .mclk    (mclk),
    .reset_n (reset_n),
    .hb      (hb)
  );

  ////////////////////////////////////////////////////////////////////////////
  // four-phase divider, one phase per clock
  always_comb begin
    next_phase = phase + 2'h1;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      phase <= PH_Q1;
    end else begin
      phase <= next_phase;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // opcode decode of the latched word
  assign is_tw   = (state == ST_EXEC) && (instr[15:2] == OP_TW_PREFIX);
  assign is_tst  = (state == ST_EXEC) && (instr[15:9] == OP_TST_PREFIX);
  assign is_xl   = (state == ST_EXEC) && (instr[15:8] == OP_XL_PREFIX);
  assign is_xf   = (state == ST_EXEC) && (instr[15:10] == OP_XF_PREFIX);
  assign cur_a   = instr[FLD_A_BIT];
  assign cur_d   = instr[FLD_D_BIT];
  assign cur_nn  = instr[1:0];
  assign cur_f   = instr[7:0];
  assign xor_res = w_reg ^ (is_xl ? cur_f : file_rdata);

  // fetch handshake, one pulse per instruction cycle at the first phase, none in the second cycle of a table write
  assign instr_load    = (state == ST_EXEC) && (phase == PH_Q1);
  assign instr_discard = ((state == ST_SKIP) || (state == ST_SKIP2)) && (phase == PH_Q1);

  // holding register write port, byte index from the pointer's low bits
  assign hb.wr_en   = (state == ST_TW2) && (phase == PH_Q4);
  assign hb.wr_idx  = table_pointer[HOLD_IDX_W-1:0];         // bits 2:0 pick the byte
  assign hb.wr_data = hold_data;
  assign hb.rd_idx  = reg_addr[HOLD_IDX_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // execution: bus writes first, instruction results override them
  always_comb begin
    next_state             = state;
    next_instr             = instr;
    next_w_reg             = w_reg;
    next_flag_n            = flag_n;
    next_flag_z            = flag_z;
    next_table_pointer     = table_pointer;
    next_table_latch       = table_latch;
    next_bank_select_value = bank_select_value;
    next_file_addr         = file_addr;
    next_file_rd           = 1'b0;
    next_file_wr           = 1'b0;
    next_file_wdata        = file_wdata;
    next_two_word_seen     = two_word_seen;
    next_hold_data         = hold_data;
    // software writes
    if (reg_wr) begin
      case (reg_addr)
        REG_W:        next_w_reg = reg_wdata;
        REG_STATUS: begin
          next_flag_n = reg_wdata[STAT_N_BIT];
          next_flag_z = reg_wdata[STAT_Z_BIT];
        end
        REG_TP_LOW:   next_table_pointer[7:0]   = reg_wdata;
        REG_TP_HIGH:  next_table_pointer[15:8]  = reg_wdata;
        REG_TP_UPPER: next_table_pointer[20:16] = reg_wdata[4:0];
        REG_LATCH:    next_table_latch          = reg_wdata;
        REG_BANK:     next_bank_select_value    = reg_wdata[BANK_W-1:0];
        default: ;
      endcase
    end
    case (state)
      ST_EXEC: begin
        if (phase == PH_Q1) begin
          next_instr = instr_word;
        end
        // operand read, bank chosen by the access bit
        if ((phase == PH_Q2) && (is_tst || is_xf)) begin
          next_file_rd   = 1'b1;
          next_file_addr = cur_a ? {bank_select_value, cur_f} : {ACCESS_BANK, cur_f};
        end
        if (phase == PH_Q4) begin
          if (is_xl) begin
            next_w_reg  = xor_res;
            next_flag_n = xor_res[BYTE_W-1];
            next_flag_z = (xor_res == 8'h00);
          end else if (is_xf) begin
            next_flag_n = xor_res[BYTE_W-1];
            next_flag_z = (xor_res == 8'h00);
            if (cur_d) begin
              next_file_wr    = 1'b1;
              next_file_wdata = xor_res;
            end else begin
              next_w_reg = xor_res;
            end
          end else if (is_tst && (file_rdata == 8'h00)) begin
            next_state = ST_SKIP;
          end else if (is_tw) begin
            next_state = ST_TW2;
            if (cur_nn == TP_PREINC) begin
              next_table_pointer = table_pointer + 21'h000001;
            end
          end
        end
      end
      ST_TW2: begin
        // second cycle: read latch, write holding register, post-adjust
        if (phase == PH_Q2) begin
          next_hold_data = table_latch;
        end
        if (phase == PH_Q4) begin
          next_state = ST_EXEC;
          case (cur_nn)
            TP_POSTINC: next_table_pointer = table_pointer + 21'h000001;
            TP_POSTDEC: next_table_pointer = table_pointer - 21'h000001;
            default: ;
          endcase
        end
      end
      ST_SKIP: begin
        // discarded word; a second word costs one more dead cycle
        if (phase == PH_Q1) begin
          next_two_word_seen = instr_two_word;
        end
        if (phase == PH_Q4) begin
          next_state = two_word_seen ? ST_SKIP2 : ST_EXEC;
        end
      end
      ST_SKIP2: begin
        if (phase == PH_Q4) begin
          next_state = ST_EXEC;
        end
      end
      default: next_state = ST_EXEC;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state             <= ST_EXEC;
      instr             <= 16'h0000;
      w_reg             <= W_RESET;
      flag_n            <= 1'b0;
      flag_z            <= 1'b0;
      table_pointer     <= TP_RESET;
      table_latch       <= LATCH_RESET;
      bank_select_value <= BANK_RESET;
      file_addr         <= 12'h000;
      file_rd           <= 1'b0;
      file_wr           <= 1'b0;
      file_wdata        <= 8'h00;
      two_word_seen     <= 1'b0;
      hold_data         <= 8'h00;
    end else begin
      state             <= next_state;
      instr             <= next_instr;
      w_reg             <= next_w_reg;
      flag_n            <= next_flag_n;
      flag_z            <= next_flag_z;
      table_pointer     <= next_table_pointer;
      table_latch       <= next_table_latch;
      bank_select_value <= next_bank_select_value;
      file_addr         <= next_file_addr;
      file_rd           <= next_file_rd;
      file_wr           <= next_file_wr;
      file_wdata        <= next_file_wdata;
      two_word_seen     <= next_two_word_seen;
      hold_data         <= next_hold_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read data, valid only in the cycle after the strobe
  always_comb begin
    next_reg_rdata = 8'h00;
    if (reg_rd) begin
      if (reg_addr[HOLD_SEL_BIT]) begin
        next_reg_rdata = hb.rd_data;
      end else begin
        case (reg_addr)
          REG_W:        next_reg_rdata = w_reg;
          REG_STATUS:   next_reg_rdata = {3'h0, flag_n, 1'b0, flag_z, 2'h0};
          REG_TP_LOW:   next_reg_rdata = table_pointer[7:0];
          REG_TP_HIGH:  next_reg_rdata = table_pointer[15:8];
          REG_TP_UPPER: next_reg_rdata = {3'h0, table_pointer[20:16]};
          REG_LATCH:    next_reg_rdata = table_latch;
          REG_BANK:     next_reg_rdata = {4'h0, bank_select_value};
          default:      next_reg_rdata = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_tw_preinc_step: assert property (
    (phase == PH_Q4 && is_tw && cur_nn == TP_PREINC) |=> table_pointer == $past(table_pointer) + 21'h000001)
    else $error("pre-increment did not step the pointer");

  a_tw_hold_index: assert property (
    (phase == PH_Q4 && is_tw && cur_nn == TP_KEEP && !reg_wr) ##1 (!reg_wr)[*4]
      |-> hb.wr_en && hb.wr_idx == $past(table_pointer[2:0], 4))
    else $error("holding write used the wrong index");

  a_tp_wraps_down: assert property (
    (hb.wr_en && cur_nn == TP_POSTDEC && table_pointer == 21'h000000) |=> table_pointer == 21'h1FFFFF)
    else $error("pointer did not wrap over 21 bits");

  a_tw_two_cycles: assert property (
    (phase == PH_Q4 && is_tw) |=> (!instr_load && !file_wr && !file_rd)[*4] ##1 instr_load)
    else $error("table write did not last two cycles");

  a_tw_flags_kept: assert property (
    (phase == PH_Q4 && is_tw && !reg_wr) |=> $stable(flag_n) && $stable(flag_z) && $stable(w_reg))
    else $error("table write touched flags");

  a_skip_on_zero: assert property (
    (phase == PH_Q4 && is_tst)
      |=> instr_discard == ($past(file_rdata) == 8'h00) && instr_load != instr_discard)
    else $error("test-and-skip did not drop the next word on zero");

  a_tst_outcome: assert property (
    (phase == PH_Q4 && is_tst && file_rdata == 8'h00) |=> instr_discard ##4 (instr_load || instr_discard))
    else $error("skip did not discard the next word");

  a_skip_two_word: assert property (
    (phase == PH_Q1 && state == ST_SKIP && instr_two_word) |-> ##4 instr_discard ##4 instr_load)
    else $error("two-word skip did not take three cycles");

  a_bank_select: assert property (
    file_rd |-> file_addr[11:8] == (cur_a ? bank_select_value : ACCESS_BANK))
    else $error("wrong bank on operand read");

  a_xor_literal: assert property (
    (phase == PH_Q4 && is_xl) |=> w_reg == ($past(w_reg) ^ $past(instr[7:0])))
    else $error("literal XOR result wrong");

  a_xor_file_dest: assert property (
    (phase == PH_Q4 && is_xf && cur_d && !reg_wr)
      |=> file_wr && file_wdata == ($past(w_reg) ^ $past(file_rdata)) && $stable(w_reg))
    else $error("file XOR destination wrong");

  a_xor_flags: assert property (
    (phase == PH_Q4 && (is_xl || is_xf))
      |=> flag_n == $past(xor_res[7]) && flag_z == ($past(xor_res) == 8'h00))
    else $error("XOR flags wrong");

endmodule // table_write_test_xor_exec
`default_nettype wire

// ===== verif/table_write_test_xor_exec_tb.sv
// self-checking bench for the table write, test-and-skip and exclusive-OR execute block
// assumes the block idles on the zero word and a data memory answering one clock after file_rd
`timescale 1ns/100ps
`default_nettype none
module table_write_test_xor_exec_tb;
  import exec_pkg::*;
  typedef struct {logic [15:0] w; logic [7:0] w0, fv; logic [11:0] fa; logic [7:0] ew, res;
    logic wr;} xor_row_t;
  typedef struct {logic [15:0] w; logic [20:0] p0; logic [7:0] lat; logic [20:0] ep;
    logic [3:0] idx;} tw_row_t;
  typedef struct {logic [7:0] fv; logic two; int ek, end_n; logic [7:0] ew;} tst_row_t;

  logic                   mclk;
  logic                   reset_n;
  logic [INSTR_W-1:0]     instr_word;
  logic                   instr_two_word;
  logic                   instr_load;
  logic                   instr_discard;
  logic [FADDR_W-1:0]     file_addr;
  logic                   file_rd;
  logic [BYTE_W-1:0]      file_rdata;
  logic                   file_wr;
  logic [BYTE_W-1:0]      file_wdata;
  logic [TP_W-1:0]        table_pointer;
  logic [REG_ADDR_W-1:0]  reg_addr;
  logic [BYTE_W-1:0]      reg_wdata;
  logic                   reg_wr;
  logic                   reg_rd;
  logic [BYTE_W-1:0]      reg_rdata;
  logic [BYTE_W-1:0]      fmem [0:4095];
  logic [FADDR_W-1:0]     rd_addr;
  logic [FADDR_W-1:0]     wr_addr;
  logic [BYTE_W-1:0]      wr_data;
  int                     wr_cnt;
  int                     err_count;
  int                     tests_run;
  int                     k;
  int                     nd;

  table_write_test_xor_exec u_table_write_test_xor_exec (
    .mclk(mclk), .reset_n(reset_n), .instr_word(instr_word), .instr_two_word(instr_two_word),
    .instr_load(instr_load), .instr_discard(instr_discard), .file_addr(file_addr),
    .file_rd(file_rd), .file_rdata(file_rdata), .file_wr(file_wr), .file_wdata(file_wdata),
    .table_pointer(table_pointer), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  ////////////////////////////////////////////////////////////////////////////
  // clock, 50 ns period
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // data memory: read data one clock after file_rd, inverted junk otherwise
  always @(posedge mclk) begin
    file_rdata <= file_rd ? fmem[file_addr] : ~file_rdata;
    if (file_rd) rd_addr <= file_addr;
    if (file_wr) begin
      fmem[file_addr] <= file_wdata;
      wr_cnt <= wr_cnt + 1;
      wr_addr <= file_addr;
      wr_data <= file_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // comparison and bus tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // read data stands only in the clock after the strobe
  task automatic check_reg(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask

  // present w until the block takes it, then present nx
  task automatic issue(input logic [15:0] w, input logic [15:0] nx, input logic nt);
    @(posedge mclk);
    instr_word <= w;
    for (int n = 0; n < 16; n++) begin
      #1;
      if (instr_load === 1'b1) break;
      if (n == 15) check({31'h0, instr_load}, 32'h1);
      @(posedge mclk);
    end
    @(posedge mclk);
    instr_word <= nx;
    instr_two_word <= nt;
  endtask

  // count clocks to the next load, replacing discarded words by the zero word
  task automatic wait_next(output int kk, output int dd);
    dd = 0;
    for (kk = 1; kk < 20; kk++) begin
      #1;
      if (instr_load === 1'b1) break;
      if (instr_discard === 1'b1) dd++;
      @(posedge mclk);
      if (dd > 0) instr_word <= 16'h0000;
      if (dd > 0) instr_two_word <= 1'b0;
    end
    @(posedge mclk);
    instr_word <= 16'h0000;
    instr_two_word <= 1'b0;
  endtask

  task automatic do_reset;
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
  endtask

  task automatic print_verdict;
    $display("tests run %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // case tables
  xor_row_t xr [6] = '{
    '{16'h0AAF, 8'hB5, 8'h00, 12'h000, 8'h1A, 8'h1A, 1'b0},
    '{16'h0A55, 8'h55, 8'h00, 12'h000, 8'h00, 8'h00, 1'b0},
    '{16'h0AF0, 8'h0F, 8'h00, 12'h000, 8'hFF, 8'hFF, 1'b0},
    '{16'h1B20, 8'hB5, 8'hAF, 12'h520, 8'hB5, 8'h1A, 1'b1},
    '{16'h1820, 8'hB5, 8'hB5, 12'h020, 8'h00, 8'h00, 1'b0},
    '{16'h1A30, 8'h01, 8'h81, 12'h030, 8'h01, 8'h80, 1'b1}};
  tw_row_t tr [5] = '{
    '{16'h000D, 21'h00A356, 8'h55, 21'h00A357, 4'hE},
    '{16'h000F, 21'h01389A, 8'h34, 21'h01389B, 4'hB},
    '{16'h000C, 21'h0000F1, 8'h77, 21'h0000F1, 4'h9},
    '{16'h000E, 21'h000000, 8'h9C, 21'h1FFFFF, 4'h8},
    '{16'h000F, 21'h1FFFFF, 8'hC3, 21'h000000, 4'h8}};
  tst_row_t sr [3] = '{'{8'h01, 1'b0, 4, 0, 8'hC3}, '{8'h00, 1'b0, 8, 1, 8'h3C},
    '{8'h00, 1'b1, 12, 2, 8'h3C}};

  // watchdog far beyond the expected run of under a thousand clocks
  initial begin
    #(50 * 20000);
    err_count++;
    print_verdict();
  end

  initial begin
    reset_n = 1'b0;
    instr_word = 16'h0000;
    instr_two_word = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    file_rdata = 8'h00;
    wr_cnt = 0;
    err_count = 0;
    tests_run = 0;
    for (int i = 0; i < 4096; i++) fmem[i] = 8'h00;
    do_reset();
    check(table_pointer, TP_RESET);
    check_reg(REG_W, W_RESET);
    check_reg(REG_LATCH, LATCH_RESET);
    check_reg(4'hE, HOLD_RESET);
    reg_write(4'h7, 8'h5A);
    check_reg(4'h7, 8'h00);
    $display("reset values done");
    reg_write(REG_BANK, 8'h05);
    for (int i = 0; i < 6; i++) begin
      reg_write(REG_W, xr[i].w0);
      fmem[xr[i].fa] = xr[i].fv;
      wr_cnt = 0;
      issue(xr[i].w, 16'h0000, 1'b0);
      repeat (5) @(posedge mclk);
      check_reg(REG_W, xr[i].ew);
      check_reg(REG_STATUS, {3'h0, xr[i].res[7], 1'b0, xr[i].res == 8'h00, 2'h0});
      check(wr_cnt, xr[i].wr);
      if (xr[i].wr) check({wr_addr, wr_data}, {xr[i].fa, xr[i].res});
      if (xr[i].w[12]) check(rd_addr, xr[i].fa);
    end
    $display("exclusive-or table done");
    for (int i = 0; i < 5; i++) begin
      reg_write(REG_TP_LOW, tr[i].p0[7:0]);
      reg_write(REG_TP_HIGH, tr[i].p0[15:8]);
      reg_write(REG_TP_UPPER, {3'h0, tr[i].p0[20:16]});
      reg_write(REG_LATCH, tr[i].lat);
      reg_write(REG_STATUS, 8'h14);
      check_reg(REG_STATUS, 8'h14);
      issue(tr[i].w, 16'h0000, 1'b0);
      wait_next(k, nd);
      check(k, 8);
      repeat (2) @(posedge mclk);
      check(table_pointer, tr[i].ep);
      check_reg(tr[i].idx, tr[i].lat);
      check_reg(REG_TP_UPPER, {3'h0, tr[i].ep[20:16]});
      check_reg(REG_STATUS, 8'h14);
    end
    check_reg(4'hA, HOLD_RESET);
    $display("table write table done");
    for (int i = 0; i < 3; i++) begin
      reg_write(REG_W, 8'h3C);
      fmem[12'h540] = sr[i].fv;
      wr_cnt = 0;
      issue(16'h6740, 16'h0AFF, sr[i].two);
      wait_next(k, nd);
      check(k, sr[i].ek);
      check(nd, sr[i].end_n);
      repeat (5) @(posedge mclk);
      check_reg(REG_W, sr[i].ew);
      check(wr_cnt, 0);
      check(rd_addr, 12'h540);
    end
    $display("test-and-skip table done");
    reg_write(REG_W, 8'h3C);
    reg_write(REG_TP_LOW, 8'hA5);
    do_reset();
    check_reg(REG_W, W_RESET);
    check_reg(4'h8, HOLD_RESET);
    check(table_pointer, TP_RESET);
    $display("second reset done");
    print_verdict();
  end
endmodule // table_write_test_xor_exec_tb
`default_nettype wire
